// file: core/ttbr_top.v
// APB register bank for thermal target, off-chip response selects and boost ratio ceiling
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ttbr_regs.vh"

module ttbr_top #(
    parameter [7:0] DEFAULT_TARGET = 8'h64
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [3:0]  active_cores,
    output reg  [8:0]  hot_alarm_temp,
    output reg  [7:0]  boost_ratio,
    output reg  [63:0] offchip_response_select_0,
    output reg  [63:0] offchip_response_select_1
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------

    wire [11:0] reg_idx;
    wire        half;
    wire        aligned;
    reg         hit;
    wire        setup;
    wire        wr_cycle;

    // byte address = 4 * (index); 64-bit registers take index and upper half at +0x2000
    assign reg_idx  = {1'b0, paddr[12:2]};
    assign half     = paddr[13];
    assign aligned  = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    assign setup    = psel && !penable;
    assign wr_cycle = psel && penable && pwrite && pready && hit;

    // known register check
    always @* begin
        case (reg_idx)
            `TTBR_IDX_THERMAL_TARGET: hit = aligned;
            `TTBR_IDX_OFFCHIP_SEL_0:  hit = aligned;
            `TTBR_IDX_OFFCHIP_SEL_1:  hit = aligned;
            `TTBR_IDX_BOOST_CEILING:  hit = aligned;
            default:                  hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------

    reg  [5:0]  offset_q;
    wire [63:0] sel0_val;
    wire [63:0] sel1_val;
    wire [63:0] ceil_val;
    wire [7:0]  picked_ratio;
    wire [63:0] thermal_val;

    // only the offset field of the thermal target is writable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_q <= `TTBR_OFS_RST;
        end else if (wr_cycle && reg_idx == `TTBR_IDX_THERMAL_TARGET && half == `TTBR_HALF_LO && pstrb[3]) begin
            offset_q <= pwdata[`TTBR_OFS_MSB:`TTBR_OFS_LSB];
        end
    end

    // read view: reserved bits zero, target fixed
    assign thermal_val = {34'h0, offset_q, DEFAULT_TARGET, 16'h0000};

    ttbr_word_reg #(.RST_VAL(`TTBR_SEL_RST)) u_sel0 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_lo   (wr_cycle && reg_idx == `TTBR_IDX_OFFCHIP_SEL_0 && half == `TTBR_HALF_LO),
        .wr_hi   (wr_cycle && reg_idx == `TTBR_IDX_OFFCHIP_SEL_0 && half == `TTBR_HALF_HI),
        .wdata   (pwdata),
        .pstrb   (pstrb),
        .value   (sel0_val)
    );

    ttbr_word_reg #(.RST_VAL(`TTBR_SEL_RST)) u_sel1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_lo   (wr_cycle && reg_idx == `TTBR_IDX_OFFCHIP_SEL_1 && half == `TTBR_HALF_LO),
        .wr_hi   (wr_cycle && reg_idx == `TTBR_IDX_OFFCHIP_SEL_1 && half == `TTBR_HALF_HI),
        .wdata   (pwdata),
        .pstrb   (pstrb),
        .value   (sel1_val)
    );

    ttbr_word_reg #(.RST_VAL(`TTBR_CEIL_RST)) u_ceil (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_lo   (wr_cycle && reg_idx == `TTBR_IDX_BOOST_CEILING && half == `TTBR_HALF_LO),
        .wr_hi   (wr_cycle && reg_idx == `TTBR_IDX_BOOST_CEILING && half == `TTBR_HALF_HI),
        .wdata   (pwdata),
        .pstrb   (pstrb),
        .value   (ceil_val)
    );

    ttbr_ratio_pick u_pick (
        .ceiling      (ceil_val),
        .active_cores (active_cores),
        .ratio        (picked_ratio)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------

    reg [63:0] rd_full;
    reg [31:0] rd_word;

    always @* begin
        case (reg_idx)
            `TTBR_IDX_THERMAL_TARGET: rd_full = thermal_val;
            `TTBR_IDX_OFFCHIP_SEL_0:  rd_full = sel0_val;
            `TTBR_IDX_OFFCHIP_SEL_1:  rd_full = sel1_val;
            `TTBR_IDX_BOOST_CEILING:  rd_full = ceil_val;
            default:                  rd_full = 64'h0000000000000000;
        endcase
        rd_word = half ? rd_full[63:32] : rd_full[31:0];
        if (!hit) begin
            rd_word = `TTBR_WORD_ZERO;
        end
    end

    // ------------------------------------------------------------
    // APB answer: no wait state, pready in first access cycle
    // ------------------------------------------------------------

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `TTBR_WORD_ZERO;
        end else if (setup) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= pwrite ? `TTBR_WORD_ZERO : rd_word;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // block outputs
    // ------------------------------------------------------------

    // effective activation temperature and current ceiling, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hot_alarm_temp            <= 9'h000;
            boost_ratio               <= 8'h00;
            offchip_response_select_0 <= `TTBR_SEL_RST;
            offchip_response_select_1 <= `TTBR_SEL_RST;
        end else begin
            hot_alarm_temp            <= {1'b0, DEFAULT_TARGET} + {3'h0, offset_q};
            boost_ratio               <= picked_ratio;
            offchip_response_select_0 <= sel0_val;
            offchip_response_select_1 <= sel1_val;
        end
    end

endmodule

// file: core/ttbr_regs.vh
// register map, field positions and reset values of the thermal target and boost ratio bank
`ifndef TTBR_REGS_VH
`define TTBR_REGS_VH

// register indices as printed; byte address is four times the index
`define TTBR_IDX_THERMAL_TARGET  12'h1A2
`define TTBR_IDX_OFFCHIP_SEL_0   12'h1A6
`define TTBR_IDX_OFFCHIP_SEL_1   12'h1A7
`define TTBR_IDX_BOOST_CEILING   12'h1AD

// 64-bit registers are split into two words; address bit 13 selects the half
`define TTBR_HALF_LO             1'b0
`define TTBR_HALF_HI             1'b1

// thermal target fields
`define TTBR_TGT_LSB             16
`define TTBR_TGT_MSB             23
`define TTBR_OFS_LSB             24
`define TTBR_OFS_MSB             29
`define TTBR_OFS_W               6

// reset values
`define TTBR_OFS_RST             6'h00
`define TTBR_SEL_RST             64'h0000000000000000
`define TTBR_CEIL_RST            64'h0000000000000000
`define TTBR_WORD_ZERO           32'h00000000

// boost ceiling: eight byte fields, one per active core count
`define TTBR_RATIO_W             8
`define TTBR_CORES_W             4

`endif

// file: core/ttbr_word_reg.v
// 64-bit read/write register written one 32-bit half at a time
`timescale 1ns/1ps
`include "ttbr_regs.vh"

module ttbr_word_reg #(
    parameter [63:0] RST_VAL = `TTBR_SEL_RST
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        wr_lo,
    input  wire        wr_hi,
    input  wire [31:0] wdata,
    input  wire [3:0]  pstrb,
    output wire [63:0] value
);

    reg [63:0] value_q;
    reg [63:0] value_d;
    integer    i;

    // byte-lane merge of the written half
    always @* begin
        value_d = value_q;
        for (i = 0; i < 4; i = i + 1) begin
            if (wr_lo && pstrb[i]) begin
                value_d[i*8 +: 8] = wdata[i*8 +: 8];
            end
            if (wr_hi && pstrb[i]) begin
                value_d[32 + i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
    end

    // storage
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value_q <= RST_VAL;
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;

endmodule

// file: core/ttbr_ratio_pick.v
// selects the boost ratio ceiling for the current active core count
`timescale 1ns/1ps
`include "ttbr_regs.vh"

module ttbr_ratio_pick (
    input  wire [63:0] ceiling,
    input  wire [3:0]  active_cores,
    output reg  [7:0]  ratio
);

    // one core uses byte 0, eight cores byte 7; zero or above eight gives zero
    always @* begin
        case (active_cores)
            4'h1:    ratio = ceiling[7:0];
            4'h2:    ratio = ceiling[15:8];
            4'h3:    ratio = ceiling[23:16];
            4'h4:    ratio = ceiling[31:24];
            4'h5:    ratio = ceiling[39:32];
            4'h6:    ratio = ceiling[47:40];
            4'h7:    ratio = ceiling[55:48];
            4'h8:    ratio = ceiling[63:56];
            default: ratio = 8'h00;
        endcase
    end

endmodule

// file: verif/ttbr_monitor.sv
// port-side assertions for the thermal target and boost ratio bank
`timescale 1ns/1ps
module ttbr_monitor #(
    parameter [7:0] DEFAULT_TARGET = 8'h64
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [15:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [3:0]  active_cores,
    input wire [8:0]  hot_alarm_temp,
    input wire [7:0]  boost_ratio,
    input wire [63:0] offchip_response_select_0,
    input wire [63:0] offchip_response_select_1
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ---------------------------------------------
    // access answer, error response and completed reads, decoded by address
    // ---------------------------------------------
    wire rd_ok  = pready && !pwrite && !pslverr;
    wire rd_tgt = rd_ok && paddr == 16'h0688;
    setup_answer_a: assert property (psel && !penable |=> pready && psel && penable) else $error("no access answer");
    target_field_a: assert property (rd_tgt |-> prdata[23:16] == DEFAULT_TARGET) else $error("bad target");
    reserved_zero_a: assert property (rd_tgt |-> prdata[15:0] == 16'h0000 && prdata[31:30] == 2'h0) else $error("rsvd");
    hot_sum_a: assert property (rd_tgt |-> hot_alarm_temp == {1'b0, DEFAULT_TARGET} + {3'h0, prdata[29:24]})
        else $error("hot sum wrong");
    sel0_mirror_a: assert property (rd_ok && paddr == 16'h0698 |-> prdata == offchip_response_select_0[31:0])
        else $error("sel0 mismatch");
    sel1_mirror_a: assert property (rd_ok && paddr == 16'h269C |-> prdata == offchip_response_select_1[63:32])
        else $error("sel1 mismatch");
    one_core_a: assert property (rd_ok && paddr == 16'h06B4 && $past(active_cores) == 4'h1 |-> boost_ratio == prdata[7:0])
        else $error("one core ratio");
    five_core_a: assert property (rd_ok && paddr == 16'h26B4 && $past(active_cores) == 4'h5 |-> boost_ratio == prdata[7:0])
        else $error("five core ratio");
    misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h00000000)
        else $error("no error on bad address");
    // main scenarios reached
    cover property (rd_tgt && prdata[29:24] == 6'h3F);
    cover property (pready && pslverr);
    cover property (rd_ok && paddr == 16'h26B4 && $past(active_cores) == 4'h5);
endmodule
bind ttbr_top ttbr_monitor #(.DEFAULT_TARGET(DEFAULT_TARGET)) mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .active_cores(active_cores), .hot_alarm_temp(hot_alarm_temp), .boost_ratio(boost_ratio),
    .offchip_response_select_0(offchip_response_select_0), .offchip_response_select_1(offchip_response_select_1));

// file: verif/ttbr_tb_top.sv
// self-checking bench for the thermal target and boost ratio bank
`timescale 1ns/1ps
module ttbr_tb_top;
    localparam [7:0] TGT = 8'h5A;
    logic pclk, presetn, psel, penable, pwrite, er;
    logic [15:0] paddr;
    logic [31:0] pwdata, rd, d, seed;
    logic [3:0]  pstrb, active_cores;
    logic [63:0] v0, v1, vc, got;
    wire  [31:0] prdata;
    wire         pready, pslverr;
    wire  [8:0]  hot_alarm_temp;
    wire  [7:0]  boost_ratio;
    wire  [63:0] sel0, sel1;
    int          miscompares, cmp_count;
    ttbr_top #(.DEFAULT_TARGET(TGT)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .active_cores(active_cores), .hot_alarm_temp(hot_alarm_temp), .boost_ratio(boost_ratio),
        .offchip_response_select_0(sel0), .offchip_response_select_1(sel1));
    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] exp_ratio(logic [63:0] c, logic [3:0] n);
        return (n >= 4'h1 && n <= 4'h8) ? c[8 * (n - 1) +: 8] : 8'h00;
    endfunction
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(logic w, logic [15:0] a, logic [31:0] wd, logic [3:0] s);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr64(logic [15:0] a, logic [63:0] v);
        apb(1'b1, a, v[31:0], 4'hF);
        apb(1'b1, a + 16'h2000, v[63:32], 4'hF);
    endtask
    task automatic rd64(logic [15:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
        got[31:0] = rd;
        apb(1'b0, a + 16'h2000, 32'h0, 4'h0);
        got[63:32] = rd;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // clock and watchdog
    initial begin pclk = 1'b0; forever #5 pclk = ~pclk; end
    initial begin #100000; miscompares++; test_done(); end
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, active_cores} = '0;
        seed = 32'h74B4087E;
        miscompares = 0;
        cmp_count = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("hot_rst", {55'h0, TGT}, {55'h0, hot_alarm_temp});
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : xs();
            apb(1'b1, 16'h0688, d, 4'hF);
            if (i == 4) apb(1'b1, 16'h0688, ~d, 4'h7);
            apb(1'b0, 16'h0688, 32'h0, 4'h0);
            chk("tgt", {32'h0, 2'h0, d[29:24], TGT, 16'h0}, {32'h0, rd});
            chk("hot", TGT + d[29:24], hot_alarm_temp);
        end
        $display("test thermal done");
        v0 = {xs(), xs()};
        v1 = {xs(), xs()};
        wr64(16'h0698, v0);
        wr64(16'h069C, v1);
        rd64(16'h0698);
        chk("sel0", v0, got);
        rd64(16'h069C);
        chk("sel1", v1, got);
        chk("sel0_out", v0, sel0);
        chk("sel1_out", v1, sel1);
        $display("test select done");
        vc = {xs(), xs()};
        wr64(16'h06B4, vc);
        for (int n = 0; n < 10; n++) begin
            active_cores <= n[3:0];
            rd64(16'h06B4);
            chk("ceil", vc, got);
            chk("ratio", exp_ratio(vc, n[3:0]), boost_ratio);
        end
        $display("test ceiling done");
        apb(1'b0, 16'h0700, 32'h0, 4'h0);
        chk("unmapped", 64'h100000000, {er, rd});
        apb(1'b0, 16'h0689, 32'h0, 4'h0);
        chk("misaligned", 64'h100000000, {er, rd});
        $display("test errors done");
        test_done();
    end
endmodule
